/* src/rwc_cfg.svh */
/*
  Constants of the reset, watchdog and clock control block:
  register offsets, field positions, reset values and timing counts.
  Assumes a 125 MHz block clock and a byte-wide register port.
*/
`ifndef RWC_CFG_SVH
`define RWC_CFG_SVH

// Register offsets on the byte-wide port
`define RWC_ADDR_INT_OSC 8'hB2
`define RWC_ADDR_EXT_OSC 8'hB1
`define RWC_ADDR_RST_SRC 8'hEF
`define RWC_ADDR_WDT_CMD 8'hFF

// Watchdog command codes and fields
`define RWC_WDT_KICK     8'hA5
`define RWC_WDT_DIS1     8'hDE
`define RWC_WDT_DIS2     8'hAD
`define RWC_WDT_LOCK     8'hFF
`define RWC_WDT_CMD_BIT  7
`define RWC_WDT_RUN_BIT  4
`define RWC_WDT_IVL_RST  3'h7
`define RWC_WDT_DIS_WIN  3'h4
`define RWC_WDT_EXP_BASE 6

// Reset source bit positions
`define RWC_RS_CMP0 5
`define RWC_RS_SW   4
`define RWC_RS_POR  1

// Reset values of the oscillator registers and the power-on reset source value
`define RWC_INT_OSC_RST 8'h04
`define RWC_EXT_OSC_RST 8'h30
`define RWC_CAUSE_POR   6'h02

// Synchroniser lanes
`define RWC_SY_VDD  0
`define RWC_SY_PIN  1
`define RWC_SY_CMP  2
`define RWC_SY_LOCK 3
`define RWC_SY_XTAL 4
`define RWC_SY_MON  5

// Timing
`define RWC_CLK_MHZ         125
`define RWC_POR_DELAY_MS    100
`define RWC_POR_DELAY_CYC   (`RWC_POR_DELAY_MS * 1000 * `RWC_CLK_MHZ)
`define RWC_MCD_TIMEOUT_US  220
`define RWC_MCD_TIMEOUT_CYC (`RWC_MCD_TIMEOUT_US * `RWC_CLK_MHZ)
`define RWC_PIN_HOLD_CYC    12

`endif

/* src/rwc_pkg.sv */
/*
  Types of the reset, watchdog and clock control block.
  Assumes rwc_cfg.svh for every numeric constant.
*/
package rwc_pkg;

  typedef logic [7:0] rwc_byte_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_POR = 2'b01,
    ST_PIN = 2'b10,
    ST_INT = 2'b11
  } rwc_rst_state_t;

  typedef struct packed {
    logic       clock_loss_detect_enable;
    logic [1:0] unused;
    logic       int_osc_freq_ready;
    logic       system_clock_source_select;
    logic       int_osc_enable;
    logic [1:0] int_osc_freq_code;
  } rwc_int_osc_t;

  typedef struct packed {
    logic       crystal_valid_flag;
    logic [2:0] ext_osc_mode;
    logic       rsvd;
    logic [2:0] ext_osc_freq_code;
  } rwc_ext_osc_t;

  typedef struct packed {
    logic cmp0_reset;
    logic software_reset_flag;
    logic watchdog_reset_flag;
    logic clock_loss_reset_flag;
    logic power_on_force_flag;
    logic pin_reset_flag;
  } rwc_cause_t;

  typedef struct packed {
    logic        running;
    logic        locked;
    logic [2:0]  interval;
    logic        armed;
    logic [2:0]  arm_cnt;
    logic [20:0] count;
    logic        expire;
  } rwc_wdt_state_t;

  typedef struct packed {
    rwc_rst_state_t rst_state;
    logic [23:0]    hold_cnt;
    rwc_cause_t     cause;
    logic           cmp0_arm;
    rwc_int_osc_t   ioc;
    rwc_ext_osc_t   xoc;
    logic [15:0]    mcd_cnt;
    logic           mon_last;
    logic [5:0]     sync1;
    logic [5:0]     sync2;
    rwc_byte_t      rdata;
  } rwc_top_state_t;

endpackage

/* src/rwc_wdt_if.sv */
/*
  Carrier between the control top and its watchdog timer.
  Assumes both ends run on the block clock.
*/
`timescale 1ns/1ps
interface rwc_wdt_if;
  logic            cmd_wr;
  rwc_pkg::rwc_byte_t cmd_data;
  logic            sys_init;
  logic            running;
  logic [2:0]      interval;
  logic            expire;

  modport ctl (output cmd_wr, output cmd_data, output sys_init,
               input running, input interval, input expire);
  modport wdt (input cmd_wr, input cmd_data, input sys_init,
               output running, output interval, output expire);
endinterface

/* src/rwc_wdt.sv */
/*
  Watchdog timer: command decode, disable window, lockout and timeout.
  Assumes command writes arrive only while the system runs.
*/
`timescale 1ns/1ps
`include "rwc_cfg.svh"
module rwc_wdt #(
  parameter int WDT_EXP_BASE = `RWC_WDT_EXP_BASE
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  rwc_wdt_if.wdt    bus
);
  import rwc_pkg::*;

  localparam rwc_wdt_state_t WDT_INIT = '{running: 1'b1, locked: 1'b0,
    interval: `RWC_WDT_IVL_RST, armed: 1'b0, arm_cnt: 3'h0, count: 21'h0, expire: 1'b0};

  rwc_wdt_state_t s;
  rwc_wdt_state_t next_s;

  // Last count before expiry: 4^(3+interval) periods
  function automatic logic [20:0] last_count(input logic [2:0] ivl);
    last_count = 21'((64'd1 << (WDT_EXP_BASE + 2 * int'(ivl))) - 64'd1);
  endfunction

  // Next state of the timer
  always_comb begin
    next_s = s;
    next_s.expire = 1'b0;
    // Window closes after the fourth clock; a completion on that clock still counts
    if (s.armed) begin
      if (s.arm_cnt == `RWC_WDT_DIS_WIN - 3'h1) begin
        next_s.armed = 1'b0;
      end else begin
        next_s.arm_cnt = s.arm_cnt + 3'h1;
      end
    end
    // Compare with >= so a shortened interval still fires
    if (s.running) begin
      if (s.count >= last_count(s.interval)) begin
        next_s.expire = 1'b1;
        next_s.count = 21'h0;
      end else begin
        next_s.count = s.count + 21'h1;
      end
    end
    if (bus.cmd_wr) begin
      next_s.armed = 1'b0;
      if (!bus.cmd_data[`RWC_WDT_CMD_BIT]) begin
        next_s.interval = bus.cmd_data[2:0];
      end
      case (bus.cmd_data)
        `RWC_WDT_KICK: begin
          next_s.running = 1'b1;
          next_s.count = 21'h0;
          next_s.expire = 1'b0;
        end
        `RWC_WDT_DIS1: begin
          next_s.armed = 1'b1;
          next_s.arm_cnt = 3'h0;
        end
        `RWC_WDT_DIS2: begin
          if (s.armed && !s.locked) begin
            next_s.running = 1'b0;
            next_s.count = 21'h0;
            next_s.expire = 1'b0;
          end
        end
        `RWC_WDT_LOCK: begin
          next_s.locked = 1'b1;
        end
        default: begin
        end
      endcase
    end
    // Every system reset restarts at the longest interval
    if (bus.sys_init) begin
      next_s = WDT_INIT;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s <= WDT_INIT;
    end else begin
      s <= next_s;
    end
  end

  assign bus.running = s.running;
  assign bus.interval = s.interval;
  assign bus.expire = s.expire;

endmodule // rwc_wdt

/* src/rwc_top.sv */
/*
  Reset sequencer, reset source flags, clock loss detector,
  oscillator control registers and watchdog for a small MCU.
  Assumes pins and analogue cells are asynchronous to I_CLK_SYS,
  a free-running 125 MHz reference clock, and I_RST_N from the
  supply monitor at power-up.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "rwc_cfg.svh"
module rwc_top #(
  parameter int POR_DELAY_CYC   = `RWC_POR_DELAY_CYC,
  parameter int MCD_TIMEOUT_CYC = `RWC_MCD_TIMEOUT_CYC,
  parameter int WDT_EXP_BASE    = `RWC_WDT_EXP_BASE
) (
  input  wire logic           I_CLK_SYS,
  input  wire logic           I_RST_N,
  input  wire logic [7:0]     I_ADDR,
  input  wire rwc_pkg::rwc_byte_t I_WDATA,
  input  wire logic           I_WR,
  input  wire logic           I_RD,
  output rwc_pkg::rwc_byte_t  O_RDATA,
  input  wire logic           I_VDD_OK,
  input  wire logic           I_RST_PIN_IN,
  output logic                O_RST_PIN_OUT,
  output logic                O_RST_PIN_OE,
  input  wire logic           I_CMP0_OUT,
  input  wire logic           I_INT_OSC_LOCK,
  input  wire logic           I_XTAL_STABLE,
  input  wire logic           I_SYSTEM_CLOCK_MON,
  output logic                O_SYS_RST_N,
  output logic                O_INT_OSC_EN,
  output logic [1:0]          O_INT_OSC_FREQ,
  output logic                O_SYSTEM_CLOCK_SEL,
  output logic                O_EXT_OSC_EN,
  output logic [2:0]          O_EXT_OSC_MODE,
  output logic [2:0]          O_EXT_OSC_FREQ,
  output logic                O_EXT_DIV2,
  output logic                O_EXT_OSC_INPUT_PIN_GROUND
);
  import rwc_pkg::*;

  localparam rwc_top_state_t TOP_INIT = '{
    rst_state: ST_POR,
    hold_cnt:  24'h0,
    cause:     rwc_cause_t'(`RWC_CAUSE_POR),
    cmp0_arm:  1'b0,
    ioc:       rwc_int_osc_t'(`RWC_INT_OSC_RST),
    xoc:       rwc_ext_osc_t'(`RWC_EXT_OSC_RST),
    mcd_cnt:   16'h0,
    mon_last:  1'b0,
    sync1:     6'h00,
    sync2:     6'h00,
    rdata:     8'h00
  };

  rwc_top_state_t s;
  rwc_top_state_t next_s;
  rwc_wdt_if      wif ();

  logic [5:0] sync_in;
  logic       vdd_ok;
  logic       pin_high;
  logic       in_run;
  logic       por_force;
  logic       sw_force;
  logic       cmp0_fire;
  logic       mcd_fire;
  logic       mon_edge;
  logic       ext_off;
  rwc_byte_t  rd_val;

  // Register address match, shared by write and read decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Modes 00x switch the external oscillator off
  function automatic logic mode_off(input logic [2:0] m);
    mode_off = (m[2:1] == 2'b00);
  endfunction

  // Watchdog timer
  rwc_wdt #(
    .WDT_EXP_BASE (WDT_EXP_BASE)
  ) u_wdt (
    .i_clk_sys (I_CLK_SYS),
    .i_rst_n   (I_RST_N),
    .bus       (wif.wdt)
  );

  // Asynchronous inputs, gathered for the two-stage synchroniser
  assign sync_in[`RWC_SY_VDD]  = I_VDD_OK;
  assign sync_in[`RWC_SY_PIN]  = I_RST_PIN_IN;
  assign sync_in[`RWC_SY_CMP]  = I_CMP0_OUT;
  assign sync_in[`RWC_SY_LOCK] = I_INT_OSC_LOCK;
  assign sync_in[`RWC_SY_XTAL] = I_XTAL_STABLE;
  assign sync_in[`RWC_SY_MON]  = I_SYSTEM_CLOCK_MON;

  // Only the second stage is ever looked at
  assign vdd_ok   = s.sync2[`RWC_SY_VDD];
  assign pin_high = s.sync2[`RWC_SY_PIN];
  assign in_run   = (s.rst_state == ST_RUN);
  assign mon_edge = s.sync2[`RWC_SY_MON] ^ s.mon_last;
  assign ext_off  = mode_off(s.xoc.ext_osc_mode);

  // Force bits of the reset source register
  assign por_force = in_run && I_WR && hit(I_ADDR, `RWC_ADDR_RST_SRC)
                     && I_WDATA[`RWC_RS_POR];
  assign sw_force  = in_run && I_WR && hit(I_ADDR, `RWC_ADDR_RST_SRC)
                     && I_WDATA[`RWC_RS_SW];

  // Comparator output low is a reset once armed
  assign cmp0_fire = s.cmp0_arm && !s.sync2[`RWC_SY_CMP];

  // Timeout of the clock loss one-shot
  assign mcd_fire = in_run && s.ioc.clock_loss_detect_enable && !mon_edge
                    && (s.mcd_cnt >= 16'(MCD_TIMEOUT_CYC - 1));

  // Commands reach the watchdog only while running
  assign wif.cmd_wr   = in_run && I_WR && hit(I_ADDR, `RWC_ADDR_WDT_CMD);
  assign wif.cmd_data = I_WDATA;
  assign wif.sys_init = !in_run;

  // Read view of the four registers
  always_comb begin
    rd_val = 8'h00;
    if (hit(I_ADDR, `RWC_ADDR_INT_OSC)) begin
      rd_val = s.ioc;
      rd_val[6:5] = 2'b00;
      rd_val[`RWC_WDT_RUN_BIT] = s.sync2[`RWC_SY_LOCK]
                                 && s.ioc.int_osc_enable && pin_high;
    end else if (hit(I_ADDR, `RWC_ADDR_EXT_OSC)) begin
      rd_val = s.xoc;
      rd_val[7] = s.sync2[`RWC_SY_XTAL] && s.xoc.ext_osc_mode[2];
      rd_val[3] = 1'b0;
    end else if (hit(I_ADDR, `RWC_ADDR_RST_SRC)) begin
      rd_val = {2'b00, s.cause};
    end else if (hit(I_ADDR, `RWC_ADDR_WDT_CMD)) begin
      rd_val = {3'b000, wif.running, 1'b0, wif.interval};
    end
  end

  // Next state of the whole block
  always_comb begin
    next_s = s;
    next_s.sync1 = sync_in;
    next_s.sync2 = s.sync1;
    next_s.mon_last = s.sync2[`RWC_SY_MON];
    next_s.rdata = I_RD ? rd_val : 8'h00;

    // Software writes while the system runs
    if (in_run && I_WR) begin
      if (hit(I_ADDR, `RWC_ADDR_INT_OSC)) begin
        next_s.ioc = I_WDATA;
        next_s.ioc.unused = 2'b00;
        next_s.ioc.int_osc_freq_ready = 1'b0;
      end
      if (hit(I_ADDR, `RWC_ADDR_EXT_OSC)) begin
        next_s.xoc = I_WDATA;
        next_s.xoc.crystal_valid_flag = 1'b0;
        next_s.xoc.rsvd = 1'b0;
      end
      if (hit(I_ADDR, `RWC_ADDR_RST_SRC)) begin
        next_s.cmp0_arm = I_WDATA[`RWC_RS_CMP0];
      end
    end

    // Clock loss counter restarts on every monitored edge
    if (in_run && s.ioc.clock_loss_detect_enable && !mon_edge) begin
      next_s.mcd_cnt = s.mcd_cnt + 16'h1;
    end else begin
      next_s.mcd_cnt = 16'h0;
    end

    // Reset sequencer
    case (s.rst_state)
      ST_RUN: begin
        next_s.hold_cnt = 24'h0;
        if (!vdd_ok || por_force) begin
          next_s.rst_state = ST_POR;
          next_s.cause = rwc_cause_t'(`RWC_CAUSE_POR);
        end else if (!pin_high) begin
          next_s.rst_state = ST_PIN;
          next_s.cause = '0;
          next_s.cause.pin_reset_flag = 1'b1;
        end else if (wif.expire) begin
          next_s.rst_state = ST_INT;
          next_s.cause = '0;
          next_s.cause.watchdog_reset_flag = 1'b1;
        end else if (mcd_fire) begin
          next_s.rst_state = ST_INT;
          next_s.cause = '0;
          next_s.cause.clock_loss_reset_flag = 1'b1;
        end else if (cmp0_fire) begin
          next_s.rst_state = ST_INT;
          next_s.cause = '0;
          next_s.cause.cmp0_reset = 1'b1;
        end else if (sw_force) begin
          next_s.rst_state = ST_INT;
          next_s.cause = '0;
          next_s.cause.software_reset_flag = 1'b1;
        end
      end
      ST_POR: begin
        // Delay restarts whenever the supply dips again
        if (!vdd_ok) begin
          next_s.hold_cnt = 24'h0;
        end else if (s.hold_cnt >= 24'(POR_DELAY_CYC - 1)) begin
          next_s.rst_state = ST_INT;
          next_s.hold_cnt = 24'h0;
        end else begin
          next_s.hold_cnt = s.hold_cnt + 24'h1;
        end
      end
      ST_PIN: begin
        // Released pin still holds the core for a short tail
        if (!vdd_ok) begin
          next_s.rst_state = ST_POR;
          next_s.hold_cnt = 24'h0;
          next_s.cause = rwc_cause_t'(`RWC_CAUSE_POR);
        end else if (!pin_high) begin
          next_s.hold_cnt = 24'h0;
        end else if (s.hold_cnt >= 24'(`RWC_PIN_HOLD_CYC - 1)) begin
          next_s.rst_state = ST_RUN;
          next_s.hold_cnt = 24'h0;
        end else begin
          next_s.hold_cnt = s.hold_cnt + 24'h1;
        end
      end
      ST_INT: begin
        // Pin is ignored here: it lags our own drive by the synchroniser
        if (!vdd_ok) begin
          next_s.rst_state = ST_POR;
          next_s.hold_cnt = 24'h0;
          next_s.cause = rwc_cause_t'(`RWC_CAUSE_POR);
        end else if (s.hold_cnt >= 24'(`RWC_PIN_HOLD_CYC - 1)) begin
          next_s.rst_state = ST_RUN;
          next_s.hold_cnt = 24'h0;
        end else begin
          next_s.hold_cnt = s.hold_cnt + 24'h1;
        end
      end
      default: begin
        next_s.rst_state = ST_POR;
        next_s.hold_cnt = 24'h0;
      end
    endcase

    // Control registers reload reset values one cycle after any reset starts
    if (!in_run) begin
      next_s.ioc = rwc_int_osc_t'(`RWC_INT_OSC_RST);
      next_s.xoc = rwc_ext_osc_t'(`RWC_EXT_OSC_RST);
      next_s.cmp0_arm = 1'b0;
      next_s.mcd_cnt = 16'h0;
    end
  end

  // State register
  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      s <= TOP_INIT;
    end else begin
      s <= next_s;
    end
  end

  // Reset outputs: only power-on drives the pin
  assign O_SYS_RST_N   = in_run;
  assign O_RST_PIN_OUT = 1'b0;
  assign O_RST_PIN_OE  = (s.rst_state == ST_POR);

  // Internal oscillator drive
  assign O_INT_OSC_EN   = s.ioc.int_osc_enable && pin_high;
  assign O_INT_OSC_FREQ = s.ioc.int_osc_freq_code;
  assign O_SYSTEM_CLOCK_SEL   = s.ioc.system_clock_source_select;

  // External oscillator drive
  assign O_EXT_OSC_EN   = !ext_off && pin_high;
  assign O_EXT_OSC_MODE = s.xoc.ext_osc_mode;
  assign O_EXT_OSC_FREQ = s.xoc.ext_osc_freq_code;
  assign O_EXT_OSC_INPUT_PIN_GROUND = ext_off;
  assign O_EXT_DIV2     = (s.xoc.ext_osc_mode == 3'h3) || (s.xoc.ext_osc_mode[2:1] == 2'b10)
                          || (s.xoc.ext_osc_mode == 3'h7);

  // Registered read data, zero outside the answer cycle
  assign O_RDATA = s.rdata;

endmodule // rwc_top

/* dv/rwc_top_props.sv */
/*
  Port checker of the reset, watchdog and clock control top.
  Assumes it is bound into rwc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module rwc_top_props import rwc_pkg::*; (
  input wire logic      I_CLK_SYS,
  input wire logic      I_RST_N,
  input wire logic [7:0] I_ADDR,
  input wire rwc_byte_t I_WDATA,
  input wire logic      I_WR,
  input wire logic      I_RD,
  input wire rwc_byte_t O_RDATA,
  input wire logic      I_RST_PIN_IN,
  input wire logic      O_RST_PIN_OE,
  input wire logic      O_SYS_RST_N,
  input wire logic      O_INT_OSC_EN,
  input wire logic [1:0] O_INT_OSC_FREQ,
  input wire logic      O_SYSTEM_CLOCK_SEL,
  input wire logic      O_EXT_OSC_EN,
  input wire logic [2:0] O_EXT_OSC_MODE,
  input wire logic [2:0] O_EXT_OSC_FREQ,
  input wire logic      O_EXT_DIV2,
  input wire logic      O_EXT_OSC_INPUT_PIN_GROUND
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // Writes only land while the system runs
  logic wr_run;
  assign wr_run = I_WR && O_SYS_RST_N;

  property p_soft_rst;
    wr_run && I_ADDR == 8'hEF && I_WDATA[4] && !I_WDATA[1] |=> (!O_SYS_RST_N && !O_RST_PIN_OE) [*8];
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missing or drove pin");
  property p_por_force;
    wr_run && I_ADDR == 8'hEF && I_WDATA[1] |=> O_RST_PIN_OE && !O_SYS_RST_N;
  endproperty
  a_por_force: assert property (p_por_force) else $error("forced power-on did not drive pin");
  property p_oe_in_rst;
    O_RST_PIN_OE |-> !O_SYS_RST_N;
  endproperty
  a_oe_in_rst: assert property (p_oe_in_rst) else $error("pin driven while running");
  property p_tail;
    $rose(O_SYS_RST_N) |-> !$past(O_SYS_RST_N, 12);
  endproperty
  a_tail: assert property (p_tail) else $error("reset shorter than 12 cycles");
  property p_pin_osc_off;
    (!I_RST_PIN_IN) [*3] |-> !O_INT_OSC_EN && !O_EXT_OSC_EN;
  endproperty
  a_pin_osc_off: assert property (p_pin_osc_off) else $error("oscillator on with pin low");
  property p_ext_decode;
    O_EXT_OSC_INPUT_PIN_GROUND == (O_EXT_OSC_MODE[2:1] == 2'h0)
      && O_EXT_OSC_EN == (O_EXT_OSC_MODE[2:1] != 2'h0 && $past(I_RST_PIN_IN, 2))
      && O_EXT_DIV2 == (O_EXT_OSC_MODE == 3'h3 || O_EXT_OSC_MODE[2:1] == 2'h2 || O_EXT_OSC_MODE == 3'h7);
  endproperty
  a_ext_decode: assert property (p_ext_decode) else $error("external mode decode wrong");
  property p_boot_int;
    (!O_SYS_RST_N) [*2] |-> !O_SYSTEM_CLOCK_SEL && O_INT_OSC_FREQ == 2'h0;
  endproperty
  a_boot_int: assert property (p_boot_int) else $error("reset left external clock selected");
  property p_ioc_wr;
    wr_run && I_ADDR == 8'hB2 |=> O_INT_OSC_FREQ == $past(I_WDATA[1:0]) && O_SYSTEM_CLOCK_SEL == $past(I_WDATA[3])
      && ($past(I_WDATA[2]) || !O_INT_OSC_EN);
  endproperty
  a_ioc_wr: assert property (p_ioc_wr) else $error("internal osc write not applied");
  property p_xoc_wr;
    wr_run && I_ADDR == 8'hB1 |=> O_EXT_OSC_MODE == $past(I_WDATA[6:4]) && O_EXT_OSC_FREQ == $past(I_WDATA[2:0]);
  endproperty
  a_xoc_wr: assert property (p_xoc_wr) else $error("external osc write not applied");
  property p_rd_stand;
    !I_RD |=> O_RDATA == 8'h00;
  endproperty
  a_rd_stand: assert property (p_rd_stand) else $error("read data held too long");
  property p_wdt_rd;
    I_RD && I_ADDR == 8'hFF |=> (O_RDATA & 8'hE8) == 8'h00;
  endproperty
  a_wdt_rd: assert property (p_wdt_rd) else $error("watchdog read has stray bits");
endmodule // rwc_top_props

bind rwc_top rwc_top_props u_props (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD),
  .O_RDATA(O_RDATA), .I_RST_PIN_IN(I_RST_PIN_IN), .O_RST_PIN_OE(O_RST_PIN_OE), .O_SYS_RST_N(O_SYS_RST_N),
  .O_INT_OSC_EN(O_INT_OSC_EN), .O_INT_OSC_FREQ(O_INT_OSC_FREQ), .O_SYSTEM_CLOCK_SEL(O_SYSTEM_CLOCK_SEL),
  .O_EXT_OSC_EN(O_EXT_OSC_EN), .O_EXT_OSC_MODE(O_EXT_OSC_MODE), .O_EXT_OSC_FREQ(O_EXT_OSC_FREQ),
  .O_EXT_DIV2(O_EXT_DIV2), .O_EXT_OSC_INPUT_PIN_GROUND(O_EXT_OSC_INPUT_PIN_GROUND)
);

/* dv/rwc_partner.sv */
/*
  Model of the reset pin circuit and the oscillator cells.
  Assumes the bench presses the pin and stops the clock on purpose.
*/
`timescale 1ns/1ps
module rwc_partner (
  input  wire logic       i_clk,
  input  wire logic       i_pull_low,
  input  wire logic       i_clk_stop,
  input  wire logic       i_pin_oe,
  input  wire logic       i_pin_out,
  input  wire logic       i_int_en,
  input  wire logic       i_ext_en,
  input  wire logic [2:0] i_ext_mode,
  input  wire logic       i_sel,
  output logic            o_pin,
  output logic            o_int_lock,
  output logic            o_xtal_ok,
  output logic            o_mon
);
  logic [2:0] int_age = 3'h0;
  logic [3:0] xt_age  = 4'h0;
  logic       mon     = 1'b0;
  // Open-drain pin with pull-up: low if anyone pulls
  assign o_pin      = !(i_pull_low || (i_pin_oe && !i_pin_out));
  assign o_int_lock = int_age[2];
  assign o_xtal_ok  = xt_age[3];
  assign o_mon      = mon;
  // Oscillators need a few cycles to settle; clock stands still when stopped
  always @(posedge i_clk) begin
    int_age <= !i_int_en ? 3'h0 : (int_age[2] ? int_age : int_age + 3'h1);
    xt_age  <= !(i_ext_en && i_ext_mode[2:1] == 2'h3) ? 4'h0 : (xt_age[3] ? xt_age : xt_age + 4'h1);
    mon     <= ((i_sel ? i_ext_en : i_int_en) && !i_clk_stop) ? !mon : mon;
  end
endmodule // rwc_partner

/* dv/rwc_top_tb_top.sv */
/*
  Self-checking bench of the reset, watchdog and clock control top.
  Assumes rwc_partner on the far side and the checker bound in.
*/
`timescale 1ns/1ps
module rwc_top_tb_top;
  import rwc_pkg::*;
  localparam int POR_CYC = 20;
  localparam int BASE    = 2;
  logic       clk = 1'b0;
  logic       rst_n, wr, rd, vdd_ok, cmp0, pull_low, clk_stop;
  logic       pin, lock, xtal, mon, pin_out, pin_oe, sys_rst_n, int_en, sel, ext_en, div2, gnd;
  logic [7:0] addr;
  logic [1:0] ifreq;
  logic [2:0] xmode, xfreq;
  rwc_byte_t  wdata, rdata, rd_val;
  int         bad_count = 0;
  int         cmp_count = 0;
  int         cyc = 0;
  int         seed = 13;
  int         n, r;
  time        t0, t_fall;

  rwc_top #(.POR_DELAY_CYC(POR_CYC), .MCD_TIMEOUT_CYC(16), .WDT_EXP_BASE(BASE)) DUT (
    .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .I_VDD_OK(vdd_ok), .I_RST_PIN_IN(pin), .O_RST_PIN_OUT(pin_out), .O_RST_PIN_OE(pin_oe), .I_CMP0_OUT(cmp0),
    .I_INT_OSC_LOCK(lock), .I_XTAL_STABLE(xtal), .I_SYSTEM_CLOCK_MON(mon), .O_SYS_RST_N(sys_rst_n),
    .O_INT_OSC_EN(int_en), .O_INT_OSC_FREQ(ifreq), .O_SYSTEM_CLOCK_SEL(sel), .O_EXT_OSC_EN(ext_en),
    .O_EXT_OSC_MODE(xmode), .O_EXT_OSC_FREQ(xfreq), .O_EXT_DIV2(div2), .O_EXT_OSC_INPUT_PIN_GROUND(gnd));
  rwc_partner u_partner (.i_clk(clk), .i_pull_low(pull_low), .i_clk_stop(clk_stop), .i_pin_oe(pin_oe),
    .i_pin_out(pin_out), .i_int_en(int_en), .i_ext_en(ext_en), .i_ext_mode(xmode), .i_sel(sel),
    .o_pin(pin), .o_int_lock(lock), .o_xtal_ok(xtal), .o_mon(mon));

  // Expected watchdog read-back and external decode {ground, div2, enable}
  function automatic rwc_byte_t wdt_rd(input logic run, input logic [2:0] ivl);
    return {3'h0, run, 1'b0, ivl};
  endfunction
  function automatic logic [2:0] ext_exp(input logic [2:0] m);
    return {m[2:1] == 2'h0, m == 3'h3 || m[2:1] == 2'h2 || m == 3'h7, m[2:1] != 2'h0};
  endfunction

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input rwc_byte_t got, input rwc_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input rwc_byte_t d);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input rwc_byte_t m, input rwc_byte_t e);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata & m, e);
  endtask
  // Ride out one reset; n returns its low cycles, bounded waits
  task automatic ride_rst;
    n = 0;
    while (sys_rst_n !== 1'b0 && n < 40) begin @(posedge clk); #1 n++; end
    t_fall = $time;
    n = 0;
    while (sys_rst_n !== 1'b1 && n < 400) begin @(posedge clk); #1 n++; end
  endtask

  initial begin
    forever #4 clk = ~clk;
  end
  // Hang guard far beyond the planned run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done;
    end
  end

  initial begin
    rst_n = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
    vdd_ok = 1'b1; cmp0 = 1'b1; pull_low = 1'b0; clk_stop = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    ride_rst;
    chk({7'h0, n >= POR_CYC + 12}, 8'h01);
    rd_chk(8'hEF, 8'hFF, 8'h02);
    rd_chk(8'hB2, 8'hFF, 8'h14);
    rd_chk(8'hB1, 8'h7F, 8'h30);
    rd_chk(8'hFF, 8'hFF, wdt_rd(1'b1, 3'h7));
    rd_chk(8'h55, 8'hFF, 8'h00);
    // Disable, then random intervals with bit 7 clear
    wr_reg(8'hFF, 8'hDE);
    wr_reg(8'hFF, 8'hAD);
    rd_chk(8'hFF, 8'h10, 8'h00);
    repeat (6) begin
      r = $random(seed);
      wr_reg(8'hFF, {1'b0, r[6:0]});
      rd_chk(8'hFF, 8'hFF, wdt_rd(1'b0, r[2:0]));
    end
    wr_reg(8'hFF, 8'h07);
    wr_reg(8'hFF, 8'hA5);
    rd_chk(8'hFF, 8'h10, 8'h10);
    // Completion one cycle past the window must not count
    wr_reg(8'hFF, 8'hDE);
    repeat (3) @(posedge clk);
    wr_reg(8'hFF, 8'hAD);
    rd_chk(8'hFF, 8'h10, 8'h10);
    wr_reg(8'hFF, 8'hFF);
    wr_reg(8'hFF, 8'hDE);
    wr_reg(8'hFF, 8'hAD);
    rd_chk(8'hFF, 8'h10, 8'h10);
    // Short interval, lock mid-count must not restart it
    wr_reg(8'hFF, 8'hA5);
    t0 = $time;
    wr_reg(8'hFF, 8'h01);
    repeat (4) @(posedge clk);
    wr_reg(8'hFF, 8'hFF);
    ride_rst;
    r = (t_fall - t0) / 8;
    chk({7'h0, r >= (1 << (BASE + 2)) - 1 && r <= (1 << (BASE + 2)) + 3}, 8'h01);
    rd_chk(8'hEF, 8'hFF, 8'h08);
    rd_chk(8'hFF, 8'hFF, wdt_rd(1'b1, 3'h7));
    wr_reg(8'hFF, 8'hDE);
    wr_reg(8'hFF, 8'hAD);
    rd_chk(8'hFF, 8'h10, 8'h00);
    wr_reg(8'hEF, 8'h00);
    rd_chk(8'hEF, 8'hFF, 8'h08);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'hB2, 8'h0C | i[7:0]);
      #1 chk({6'h0, ifreq}, i[7:0]);
    end
    chk({7'h0, sel}, 8'h01);
    wr_reg(8'hEF, 8'h10);
    ride_rst;
    chk({7'h0, n >= 11 && n <= 13}, 8'h01);
    chk({7'h0, sel}, 8'h00);
    rd_chk(8'hEF, 8'hFF, 8'h10);
    rd_chk(8'hB2, 8'h0F, 8'h04);
    // Comparator low is harmless until armed
    cmp0 <= 1'b0;
    repeat (10) @(posedge clk);
    #1 chk({7'h0, sys_rst_n}, 8'h01);
    wr_reg(8'hEF, 8'h20);
    ride_rst;
    cmp0 <= 1'b1;
    rd_chk(8'hEF, 8'hFF, 8'h20);
    // Stopped clock only matters with the detector on
    clk_stop <= 1'b1;
    repeat (30) @(posedge clk);
    #1 chk({7'h0, sys_rst_n}, 8'h01);
    wr_reg(8'hB2, 8'h84);
    ride_rst;
    clk_stop <= 1'b0;
    rd_chk(8'hEF, 8'hFF, 8'h04);
    wr_reg(8'hB2, 8'h00);
    #1 chk({7'h0, int_en}, 8'h00);
    rd_chk(8'hB2, 8'hFF, 8'h00);
    wr_reg(8'hB2, 8'h04);
    for (int m = 0; m < 8; m++) begin
      r = $random(seed);
      wr_reg(8'hB1, {1'b0, m[2:0], 1'b0, r[2:0]});
      #1 chk({5'h0, gnd, div2, ext_en}, {5'h0, ext_exp(m[2:0])});
      chk({2'h0, xmode, xfreq}, {2'h0, m[2:0], r[2:0]});
    end
    wr_reg(8'hB1, 8'h67);
    repeat (20) @(posedge clk);
    rd_chk(8'hB1, 8'h80, 8'h80);
    wr_reg(8'hB1, 8'h20);
    rd_chk(8'hB1, 8'h80, 8'h00);
    // Pin pressed from outside
    pull_low <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk({6'h0, int_en, ext_en}, 8'h00);
    pull_low <= 1'b0;
    ride_rst;
    chk({7'h0, n >= 12}, 8'h01);
    rd_chk(8'hEF, 8'hFF, 8'h01);
    wr_reg(8'hEF, 8'h12);
    #1 chk({7'h0, pin_oe}, 8'h01);
    ride_rst;
    chk({7'h0, n >= POR_CYC + 12}, 8'h01);
    rd_chk(8'hEF, 8'hFF, 8'h02);
    test_done;
  end
endmodule // rwc_top_tb_top
